/* File: itp_consts.svh */
// offsets, field positions, reset values and fixed counts of the
// trigger, pending-clear and forward-clear register block
// assumes inclusion by bare name from the package only; the design files take the macros from it
`ifndef ITP_CONSTS_SVH
`define ITP_CONSTS_SVH

// ==========================================================
// register bank base offsets, byte addresses
`define ITP_PCLR_BASE 16'h0280
`define ITP_CFG_BASE 16'h0C00
`define ITP_FWDX_BASE 16'h1400
`define ITP_CFGX_BASE 16'h3000

// ==========================================================
// layout
`define ITP_BITS_PER_REG 32
`define ITP_FIELDS_PER_REG 16
`define ITP_NUM_SGI 16
`define ITP_NUM_PRIV 32
`define ITP_MAX_BANKED_PE 8
`define ITP_EXT_FIRST_ID 16'h1000
`define ITP_CFG_RES_MASK 32'h5555_5555

// ==========================================================
// reset values
`define ITP_RST_WORD 32'h0000_0000

`endif

/* File: itp_pend_cell.sv */
// per-interrupt pending state: latched and level-driven parts
// assumes set, clear and level inputs synchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none

module itp_pend_cell #(
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pend_set,
  input wire logic [W-1:0] pend_clr,
  input wire logic [W-1:0] edge_cfg,
  input wire logic [W-1:0] level_in,
  output logic [W-1:0] pend_out
);
  logic [W-1:0] latch_reg;
  logic [W-1:0] latch_next;
  logic [W-1:0] lvl_prev_reg;
  logic [W-1:0] pend_next;
  logic [W-1:0] lvl_hold;
  logic [W-1:0] rise;
  logic [W-1:0] kill;

  // ==========================================================
  // next state
  assign rise = edge_cfg & level_in & ~lvl_prev_reg;
  assign lvl_hold = ~edge_cfg & level_in;
  // set wins over a clear in the same cycle
  assign latch_next = (latch_reg & ~pend_clr) | pend_set | rise;
  assign pend_next = latch_next | lvl_hold;
  assign kill = pend_clr & ~pend_set & ~rise & ~lvl_hold;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_reg <= '0;
      lvl_prev_reg <= '0;
      pend_out <= '0;
    end else begin
      latch_reg <= latch_next;
      lvl_prev_reg <= level_in;
      pend_out <= pend_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  set_wins_a : assert property ((|pend_set) |=> ((pend_out & $past(pend_set)) == $past(pend_set)))
    else $error("pending set lost");
  clr_pend_a : assert property ((|kill) |=> ((pend_out & $past(kill)) == '0))
    else $error("clear-pending did not clear");
  level_hold_a : assert property ((|lvl_hold) |=> ((pend_out & $past(lvl_hold)) == $past(lvl_hold)))
    else $error("asserted level interrupt lost pending");
endmodule : itp_pend_cell

`default_nettype wire

/* File: itp_pkg.sv */
// types shared by the trigger and pending-clear register block
// assumes itp_consts.svh is reachable on the include path
package itp_pkg;
  `include "itp_consts.svh"

  typedef logic [31:0] itp_word_t;
  typedef logic [15:0] itp_addr_t;

  // register bank hit by an access
  typedef enum logic [4:0] {
    ITP_TGT_NONE = 5'b00001,
    ITP_TGT_FWDX = 5'b00010,
    ITP_TGT_CFG = 5'b00100,
    ITP_TGT_CFGX = 5'b01000,
    ITP_TGT_PCLR = 5'b10000
  } itp_tgt_e;
endpackage : itp_pkg

/* File: itp_trig_pend_regs.sv */
// forward-clear (extended), trigger configuration and clear-pending banks
// assumes one access per request cycle; group, routing and set inputs
// come from the rest of the distributor, synchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none

module itp_trig_pend_regs
  import itp_pkg::*;
#(
  parameter int NUM_BASE_REGS = 2,
  parameter bit EXT_PRESENT = 1'b1,
  parameter int EXT_RANGE_SIZE = 0,
  parameter int NUM_PE = 8,
  parameter logic [15:0] PPI_PROG = 16'hFFFF,
  parameter logic [32*NUM_BASE_REGS-33:0] SPI_IMPL = '1,
  parameter logic [32*(EXT_RANGE_SIZE+1)-1:0] EXT_IMPL = '1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [15:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  input wire logic acc_secure,
  input wire logic [7:0] pe_index,
  input wire logic security_disable_ctl,
  input wire logic are_secure,
  input wire logic are_nonsecure,
  input wire logic [32*NUM_BASE_REGS-33:0] spi_grp_sec,
  input wire logic [32*NUM_PE-1:0] priv_grp_sec,
  input wire logic [32*(EXT_RANGE_SIZE+1)-1:0] ext_grp_sec,
  input wire logic [32*NUM_BASE_REGS-1:0] nonsecure_access_grant,
  input wire logic [32*(EXT_RANGE_SIZE+1)-1:0] ext_fwd_set,
  input wire logic [32*NUM_BASE_REGS-33:0] spi_pend_set,
  input wire logic [32*NUM_BASE_REGS-33:0] spi_level,
  input wire logic [32*NUM_PE-1:0] priv_pend_set,
  input wire logic [32*NUM_PE-1:0] priv_level,
  output logic [32*(EXT_RANGE_SIZE+1)-1:0] ext_fwd_en,
  output logic [32*NUM_BASE_REGS-33:0] spi_edge_cfg,
  output logic [16*NUM_PE-1:0] priv_edge_cfg,
  output logic [32*(EXT_RANGE_SIZE+1)-1:0] ext_edge_cfg,
  output logic [32*NUM_BASE_REGS-33:0] spi_pend,
  output logic [32*NUM_PE-1:0] priv_pend,
  output logic [31:0] rd_data,
  output logic rd_valid
);
  localparam int BASE_N = 32 * NUM_BASE_REGS;
  localparam int SPI_N = BASE_N - `ITP_NUM_PRIV;
  localparam int EXT_N = 32 * (EXT_RANGE_SIZE + 1);
  localparam int PRIV_N = 32 * NUM_PE;

  // ==========================================================
  // helpers
  function automatic logic reg_hit(input itp_addr_t addr, input itp_addr_t base, input int cnt);
    int a;
    int b;
    a = int'(addr);
    b = int'(base);
    return (addr[1:0] == 2'b00) && (a >= b) && (a < b + 4 * cnt);
  endfunction : reg_hit

  function automatic itp_addr_t reg_idx(input itp_addr_t addr, input itp_addr_t base);
    itp_addr_t d;
    d = addr - base;
    return {2'b00, d[15:2]};
  endfunction : reg_idx

  // affinity routing of the interrupt's own security state
  function automatic logic are_of(input logic sec, input logic ars, input logic arn);
    return sec ? ars : arn;
  endfunction : are_of

  // ==========================================================
  // decode
  logic hit_fwdx;
  logic hit_cfg;
  logic hit_cfgx;
  logic hit_pclr;
  itp_tgt_e tgt;
  itp_addr_t fidx;
  itp_addr_t cidx;
  itp_addr_t xidx;
  itp_addr_t pidx;
  logic rd_req;
  logic wr_req;
  logic ns;
  logic ds;
  logic pe_ok;
  logic [2:0] pe_sel;

  assign hit_fwdx = EXT_PRESENT && reg_hit(acc_addr, `ITP_FWDX_BASE, EXT_RANGE_SIZE + 1);
  assign hit_cfg = reg_hit(acc_addr, `ITP_CFG_BASE, 2 * NUM_BASE_REGS);
  assign hit_cfgx = EXT_PRESENT && reg_hit(acc_addr, `ITP_CFGX_BASE, 2 * (EXT_RANGE_SIZE + 1));
  assign hit_pclr = reg_hit(acc_addr, `ITP_PCLR_BASE, NUM_BASE_REGS);
  assign tgt = hit_fwdx ? ITP_TGT_FWDX : hit_cfg ? ITP_TGT_CFG : hit_cfgx ? ITP_TGT_CFGX :
               hit_pclr ? ITP_TGT_PCLR : ITP_TGT_NONE;
  assign fidx = reg_idx(acc_addr, `ITP_FWDX_BASE);
  assign cidx = reg_idx(acc_addr, `ITP_CFG_BASE);
  assign xidx = reg_idx(acc_addr, `ITP_CFGX_BASE);
  assign pidx = reg_idx(acc_addr, `ITP_PCLR_BASE);
  assign rd_req = acc_valid && !acc_write;
  assign wr_req = acc_valid && acc_write;
  assign ns = ~acc_secure;
  assign ds = security_disable_ctl;
  // elements at index 8 and above see the banked words as zero
  assign pe_ok = (int'(pe_index) < NUM_PE) && (int'(pe_index) < `ITP_MAX_BANKED_PE);
  assign pe_sel = pe_ok ? pe_index[2:0] : 3'h0;

  // ==========================================================
  // state
  logic [EXT_N-1:0] fwd_clr;
  logic [SPI_N-1:0] spi_cfg_we;
  logic [16*NUM_PE-1:0] ppi_cfg_we;
  logic [EXT_N-1:0] ext_cfg_we;
  logic [SPI_N-1:0] spi_cfg_wv;
  logic [16*NUM_PE-1:0] ppi_cfg_wv;
  logic [EXT_N-1:0] ext_cfg_wv;
  logic [SPI_N-1:0] spi_clr;
  logic [PRIV_N-1:0] priv_clr;
  logic [PRIV_N-1:0] priv_edge_all;
  logic [31:0] rv_fwdx;
  logic [31:0] rv_cfg;
  logic [31:0] rv_cfgx;
  logic [31:0] rv_pclr;
  logic [31:0] rd_word;

  // ==========================================================
  // forward-clear, extended range
  always_comb begin
    logic s;
    logic ok;
    s = 1'b0;
    ok = 1'b0;
    rv_fwdx = '0;
    fwd_clr = '0;
    for (int i = 0; i < EXT_N; i++) begin
      s = ext_grp_sec[i] & ~ds;
      ok = EXT_IMPL[i] & are_of(s, are_secure, are_nonsecure) & ~(ns & s);
      if (i / 32 == int'(fidx)) begin
        rv_fwdx[i % 32] = ext_fwd_en[i] & ok;
        fwd_clr[i] = wr_req & hit_fwdx & ok & acc_wdata[i % 32];
      end
    end
  end

  // ==========================================================
  // trigger configuration, base range
  always_comb begin
    logic s;
    logic ok;
    int f;
    int p;
    s = 1'b0;
    ok = 1'b0;
    f = 0;
    p = 0;
    rv_cfg = '0;
    spi_cfg_we = '0;
    spi_cfg_wv = '0;
    ppi_cfg_we = '0;
    ppi_cfg_wv = '0;
    for (int m = 0; m < BASE_N; m++) begin
      f = m % `ITP_FIELDS_PER_REG;
      if (m < `ITP_NUM_PRIV) begin
        p = int'(pe_sel) * 32 + m;
        s = priv_grp_sec[p] & ~ds;
        ok = pe_ok & ~are_of(s, are_secure, are_nonsecure) & ~(ns & s);
      end else begin
        s = spi_grp_sec[m - 32] & ~ds;
        ok = SPI_IMPL[m - 32] & ~(ns & s);
      end
      if (m / `ITP_FIELDS_PER_REG == int'(cidx)) begin
        if (m < `ITP_NUM_SGI) begin
          rv_cfg[2 * f + 1] = ok;
        end else if (m < `ITP_NUM_PRIV) begin
          p = int'(pe_sel) * 16 + m - 16;
          rv_cfg[2 * f + 1] = ok & priv_edge_cfg[p];
          ppi_cfg_we[p] = wr_req & hit_cfg & ok & PPI_PROG[m - 16];
          ppi_cfg_wv[p] = acc_wdata[2 * f + 1];
        end else begin
          rv_cfg[2 * f + 1] = ok & spi_edge_cfg[m - 32];
          spi_cfg_we[m - 32] = wr_req & hit_cfg & ok;
          spi_cfg_wv[m - 32] = acc_wdata[2 * f + 1];
        end
      end
    end
  end

  // ==========================================================
  // trigger configuration, extended range
  always_comb begin
    logic s;
    logic ok;
    s = 1'b0;
    ok = 1'b0;
    rv_cfgx = '0;
    ext_cfg_we = '0;
    ext_cfg_wv = '0;
    for (int m = 0; m < EXT_N; m++) begin
      s = ext_grp_sec[m] & ~ds;
      ok = EXT_IMPL[m] & are_of(s, are_secure, are_nonsecure) & ~(ns & s);
      if (m / `ITP_FIELDS_PER_REG == int'(xidx)) begin
        rv_cfgx[2 * (m % 16) + 1] = ok & ext_edge_cfg[m];
        ext_cfg_we[m] = wr_req & hit_cfgx & ok;
        ext_cfg_wv[m] = acc_wdata[2 * (m % 16) + 1];
      end
    end
  end

  // ==========================================================
  // clear-pending, base range
  always_comb begin
    logic s;
    logic ok;
    int p;
    s = 1'b0;
    ok = 1'b0;
    p = 0;
    rv_pclr = '0;
    spi_clr = '0;
    priv_clr = '0;
    for (int m = 0; m < BASE_N; m++) begin
      if (m < `ITP_NUM_PRIV) begin
        p = int'(pe_sel) * 32 + m;
        s = priv_grp_sec[p] & ~ds;
        ok = pe_ok & ~are_of(s, are_secure, are_nonsecure);
      end else begin
        s = spi_grp_sec[m - 32] & ~ds;
        ok = SPI_IMPL[m - 32];
      end
      // grant opens secure bits to non-secure only without affinity routing
      ok = ok & ~(ns & s & (~nonsecure_access_grant[m] | are_of(s, are_secure, are_nonsecure)));
      if (m / 32 == int'(pidx)) begin
        if (m < `ITP_NUM_PRIV) begin
          rv_pclr[m % 32] = ok & priv_pend[p];
          priv_clr[p] = wr_req & hit_pclr & ok & acc_wdata[m % 32] & (m >= `ITP_NUM_SGI);
        end else begin
          rv_pclr[m % 32] = ok & spi_pend[m - 32];
          spi_clr[m - 32] = wr_req & hit_pclr & ok & acc_wdata[m % 32];
        end
      end
    end
  end

  // software-generated interrupts always count as edge
  always_comb begin
    priv_edge_all = '0;
    for (int e = 0; e < NUM_PE; e++) begin
      priv_edge_all[e * 32 +: 32] = {priv_edge_cfg[e * 16 +: 16], 16'hFFFF};
    end
  end

  assign rd_word = (tgt == ITP_TGT_FWDX) ? rv_fwdx : (tgt == ITP_TGT_CFG) ? rv_cfg :
                   (tgt == ITP_TGT_CFGX) ? rv_cfgx : (tgt == ITP_TGT_PCLR) ? rv_pclr :
                   `ITP_RST_WORD;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_fwd_en <= '0;
      spi_edge_cfg <= '0;
      priv_edge_cfg <= '0;
      ext_edge_cfg <= '0;
      rd_data <= `ITP_RST_WORD;
      rd_valid <= 1'b0;
    end else begin
      // set from the enable side wins over a clear
      ext_fwd_en <= (ext_fwd_en & ~fwd_clr) | ext_fwd_set;
      spi_edge_cfg <= (spi_edge_cfg & ~spi_cfg_we) | (spi_cfg_we & spi_cfg_wv);
      priv_edge_cfg <= (priv_edge_cfg & ~ppi_cfg_we) | (ppi_cfg_we & ppi_cfg_wv);
      ext_edge_cfg <= (ext_edge_cfg & ~ext_cfg_we) | (ext_cfg_we & ext_cfg_wv);
      rd_data <= rd_req ? rd_word : `ITP_RST_WORD;
      rd_valid <= rd_req;
    end
  end

  itp_pend_cell #(.W(SPI_N)) u_spi_pend (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pend_set(spi_pend_set),
    .pend_clr(spi_clr),
    .edge_cfg(spi_edge_cfg),
    .level_in(spi_level),
    .pend_out(spi_pend)
  );

  itp_pend_cell #(.W(PRIV_N)) u_priv_pend (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pend_set(priv_pend_set),
    .pend_clr(priv_clr),
    .edge_cfg(priv_edge_all),
    .level_in(priv_level),
    .pend_out(priv_pend)
  );

  // ==========================================================
  // checks
  logic [EXT_N-1:0] fwd_kill;
  logic [EXT_N-1:0] fwd_sec;
  logic ns_fwd_wr;
  logic [PRIV_N-1:0] sgi_mask;
  assign fwd_kill = fwd_clr & ~ext_fwd_set;
  assign fwd_sec = ext_grp_sec & ~ext_fwd_set;
  assign ns_fwd_wr = wr_req && hit_fwdx && ns && !ds;
  assign sgi_mask = {NUM_PE{16'h0000, 16'hFFFF}};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence rd_issue;
    rd_req;
  endsequence
  sequence zero_answer;
    rd_valid && (rd_data == 32'h0000_0000);
  endsequence

  rd_resp_a : assert property (rd_issue |=> rd_valid)
    else $error("read answer missing");
  fwd_clear_a : assert property ((|fwd_kill) |=> ((ext_fwd_en & $past(fwd_kill)) == '0))
    else $error("forward-clear write left forwarding on");
  fwd_keep_a : assert property (wr_req && hit_fwdx && acc_wdata == 32'h0000_0000 |=>
      ext_fwd_en == ($past(ext_fwd_en) | $past(ext_fwd_set)))
    else $error("zero write changed forwarding");
  fwd_ns_a : assert property (ns_fwd_wr |=>
      ((($past(ext_fwd_en) & $past(fwd_sec)) & ~ext_fwd_en) == '0))
    else $error("non-secure write cleared secure forwarding");
  sgi_cfg_ro_a : assert property (wr_req && hit_cfg && cidx == 16'h0000 |=>
      priv_edge_cfg == $past(priv_edge_cfg))
    else $error("write to first trigger word changed state");
  cfg_res_a : assert property (rd_req && (hit_cfg || hit_cfgx) |=>
      ((rd_data & `ITP_CFG_RES_MASK) == 32'h0000_0000))
    else $error("reserved trigger bit read non-zero");
  hi_pe_a : assert property (rd_req && !pe_ok && ((hit_cfg && cidx == 16'h0001) ||
      (hit_pclr && pidx == 16'h0000)) |=> zero_answer)
    else $error("banked word visible to high element");
  unmapped_a : assert property (rd_req && tgt == ITP_TGT_NONE |=> zero_answer)
    else $error("unmapped read non-zero");
  priv_are_a : assert property (rd_req && hit_pclr && pidx == 16'h0000 && are_secure &&
      are_nonsecure |=> zero_answer)
    else $error("private clear-pending visible under affinity routing");
  sgi_pclr_a : assert property (wr_req && hit_pclr |=>
      ((($past(priv_pend) & sgi_mask) & ~priv_pend) == '0))
    else $error("clear-pending reached a software-generated interrupt");
endmodule : itp_trig_pend_regs

`default_nettype wire

/* File: itp_trig_pend_regs_test.sv */
// self-checking bench for the trigger, pending-clear and forward-clear banks
// assumes itp_pkg and itp_consts.svh compiled first; the bench drives every port
`timescale 1ns/1ns
`default_nettype none

module itp_trig_pend_regs_test;
  import itp_pkg::*;
  localparam logic [31:0] SPI_IM = 32'h7FFF_FFFF;
  localparam logic [31:0] EXT_IM = 32'hFFFF_FFFE;
  localparam logic [31:0] HI = 32'hAAAA_AAAA;
  logic sys_clk, arst_n, acc_valid, acc_write, acc_secure;
  logic [15:0] acc_addr;
  logic [31:0] acc_wdata, rd_data, spi_grp_sec, ext_grp_sec, ext_fwd_set, spi_pend_set, spi_level;
  logic [7:0] pe_index;
  logic security_disable_ctl, are_secure, are_nonsecure, rd_valid;
  logic [255:0] priv_grp_sec, priv_pend_set, priv_level, priv_pend;
  logic [63:0] nonsecure_access_grant;
  logic [31:0] ext_fwd_en, spi_edge_cfg, ext_edge_cfg, spi_pend, w, w2, w3;
  logic [127:0] priv_edge_cfg;
  logic [31:0] exp_q [$];
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed;
  logic [15:0] rst_addr [8] = '{16'h1400, 16'h0C00, 16'h0C04, 16'h0C08, 16'h3000,
                                16'h0280, 16'h1404, 16'h0282};
  logic [31:0] rst_exp [8] = '{32'h0000_0000, HI, 32'h0000_0000, 32'h0000_0000,
                               32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  itp_trig_pend_regs #(.SPI_IMPL(SPI_IM), .EXT_IMPL(EXT_IM)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_secure(acc_secure),
    .pe_index(pe_index), .security_disable_ctl(security_disable_ctl),
    .are_secure(are_secure), .are_nonsecure(are_nonsecure), .spi_grp_sec(spi_grp_sec),
    .priv_grp_sec(priv_grp_sec), .ext_grp_sec(ext_grp_sec),
    .nonsecure_access_grant(nonsecure_access_grant), .ext_fwd_set(ext_fwd_set),
    .spi_pend_set(spi_pend_set), .spi_level(spi_level), .priv_pend_set(priv_pend_set),
    .priv_level(priv_level), .ext_fwd_en(ext_fwd_en), .spi_edge_cfg(spi_edge_cfg),
    .priv_edge_cfg(priv_edge_cfg), .ext_edge_cfg(ext_edge_cfg), .spi_pend(spi_pend),
    .priv_pend(priv_pend), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // comparison, access and closing tasks
  function automatic logic [15:0] hi16(input logic [31:0] v);
    for (int i = 0; i < 16; i++) hi16[i] = v[2*i+1];
  endfunction : hi16

  function automatic logic [31:0] fmask(input logic [15:0] impl);
    fmask = '0;
    for (int i = 0; i < 16; i++) fmask[2*i+1] = impl[i];
  endfunction : fmask

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // reads queue their expected word; the monitor below compares it
  task automatic acc(input logic wr, input logic sec, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    acc_valid = 1'b1;
    acc_write = wr;
    acc_secure = sec;
    acc_addr = a;
    acc_wdata = wr ? d : $random(seed);
    if (!wr) exp_q.push_back(d);
  endtask : acc

  task automatic idle;
    @(posedge sys_clk);
    #1;
    acc_valid = 1'b0;
  endtask : idle

  task automatic results;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // ==========================================================
  // read-data monitor, mid-cycle so the pulse is settled
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("wrong value at %0t: got %0h expected none", $time, rd_data);
      end else begin
        check(rd_data, exp_q.pop_front());
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 8225;
    {acc_valid, acc_write, acc_addr, acc_wdata, acc_secure, pe_index} = '0;
    {security_disable_ctl, are_nonsecure, spi_grp_sec, priv_grp_sec} = '0;
    {nonsecure_access_grant, ext_fwd_set, spi_pend_set, spi_level} = '0;
    {priv_pend_set, priv_level} = '0;
    ext_grp_sec = '1;
    are_secure = 1'b1;
    arst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    check({ext_fwd_en, spi_edge_cfg, ext_edge_cfg, spi_pend, priv_pend[31:0]}, '0);
    foreach (rst_addr[i]) acc(1'b0, 1'b1, rst_addr[i], rst_exp[i]);
    idle();
    ext_fwd_set = '1;
    @(posedge sys_clk);
    #1 ext_fwd_set = '0;
    w = $random(seed);
    acc(1'b0, 1'b1, 16'h1400, EXT_IM);
    acc(1'b1, 1'b1, 16'h1400, w);
    acc(1'b1, 1'b0, 16'h1400, '1);
    acc(1'b0, 1'b0, 16'h1400, '0);
    acc(1'b1, 1'b1, 16'h1400, '0);
    acc(1'b0, 1'b1, 16'h1400, EXT_IM & ~w);
    idle();
    check(ext_fwd_en & EXT_IM, EXT_IM & ~w);
    are_secure = 1'b0;
    acc(1'b0, 1'b1, 16'h1400, '0);
    acc(1'b1, 1'b1, 16'h1400, '1);
    idle();
    are_secure = 1'b1;
    acc(1'b0, 1'b1, 16'h1400, EXT_IM & ~w);
    w2 = $random(seed);
    w3 = $random(seed);
    acc(1'b1, 1'b1, 16'h0C08, w2);
    acc(1'b1, 1'b1, 16'h0C0C, w3);
    acc(1'b0, 1'b1, 16'h0C08, w2 & fmask(SPI_IM[15:0]));
    acc(1'b0, 1'b1, 16'h0C0C, w3 & fmask(SPI_IM[31:16]));
    acc(1'b0, 1'b1, 16'h0C10, '0);
    acc(1'b1, 1'b1, 16'h0C00, '0);
    acc(1'b0, 1'b1, 16'h0C00, HI);
    idle();
    check(spi_edge_cfg & SPI_IM, {hi16(w3), hi16(w2)} & SPI_IM);
    pe_index = 8'h03;
    acc(1'b1, 1'b1, 16'h0C04, w);
    acc(1'b0, 1'b1, 16'h0C04, w & HI);
    idle();
    check(priv_edge_cfg[48 +: 16], hi16(w));
    pe_index = 8'h09;
    acc(1'b0, 1'b1, 16'h0C04, '0);
    acc(1'b1, 1'b1, 16'h0C04, ~w);
    idle();
    pe_index = 8'h03;
    are_nonsecure = 1'b1;
    acc(1'b0, 1'b1, 16'h0C04, '0);
    acc(1'b1, 1'b1, 16'h0C04, '0);
    idle();
    are_nonsecure = 1'b0;
    acc(1'b0, 1'b1, 16'h0C04, w & HI);
    // forwarding off before the extended trigger fields change
    acc(1'b1, 1'b1, 16'h1400, '1);
    acc(1'b1, 1'b1, 16'h3000, w);
    acc(1'b1, 1'b1, 16'h3004, w2);
    acc(1'b1, 1'b0, 16'h3004, '0);
    acc(1'b0, 1'b0, 16'h3000, '0);
    acc(1'b0, 1'b1, 16'h3000, w & fmask(EXT_IM[15:0]));
    acc(1'b0, 1'b1, 16'h3004, w2 & fmask(EXT_IM[31:16]));
    acc(1'b0, 1'b1, 16'h3008, '0);
    acc(1'b1, 1'b1, 16'h0C08, '0);
    acc(1'b1, 1'b1, 16'h0C0C, HI);
    idle();
    check(ext_edge_cfg & EXT_IM, {hi16(w2), hi16(w)} & EXT_IM);
    pe_index = 8'h00;
    spi_level = 32'h0000_0020;
    spi_pend_set = '1;
    priv_pend_set[0] = 1'b1;
    priv_pend_set[20] = 1'b1;
    @(posedge sys_clk);
    #1;
    spi_pend_set = '0;
    priv_pend_set = '0;
    acc(1'b0, 1'b1, 16'h0284, SPI_IM);
    idle();
    spi_grp_sec = 32'h0000_000F;
    are_secure = 1'b0;
    nonsecure_access_grant[35:32] = 4'b1100;
    acc(1'b0, 1'b0, 16'h0284, SPI_IM & ~32'h0000_0003);
    acc(1'b1, 1'b0, 16'h0284, '1);
    acc(1'b0, 1'b1, 16'h0284, 32'h0000_0023);
    w = $random(seed);
    acc(1'b1, 1'b1, 16'h0284, w);
    acc(1'b1, 1'b1, 16'h0284, '0);
    acc(1'b0, 1'b1, 16'h0284, (32'h0000_0023 & ~w) | 32'h0000_0020);
    idle();
    check(spi_pend & SPI_IM, (32'h0000_0023 & ~w) | 32'h0000_0020);
    // field of the pending level interrupt 37 left alone
    acc(1'b1, 1'b0, 16'h0C08, 32'hAAAA_A2AA);
    acc(1'b0, 1'b1, 16'h0C08, 32'hAAAA_A200);
    acc(1'b1, 1'b1, 16'h0280, '1);
    acc(1'b0, 1'b1, 16'h0280, 32'h0000_0001);
    idle();
    check(priv_pend[31:0], 32'h0000_0001);
    are_secure = 1'b1;
    are_nonsecure = 1'b1;
    acc(1'b0, 1'b1, 16'h0280, '0);
    idle();
    are_nonsecure = 1'b0;
    pe_index = 8'h09;
    acc(1'b0, 1'b1, 16'h0280, '0);
    idle();
    repeat (3) @(posedge sys_clk);
    check(exp_q.size(), 0);
    results();
  end
endmodule : itp_trig_pend_regs_test

`default_nettype wire
